// ===== rtl/blit_dst_pkg.sv
/*
 * Shared constants and carrier types for the destination address generator.
 * Assumes a host register port with byte enables and a 12-bit byte offset.
 */
package blit_dst_pkg;

   // Register offsets.
   localparam logic [11:0] OFF_DEST_BASE   = 12'h018;
   localparam logic [11:0] OFF_DEST_STRIDE = 12'h028;

   // Base register layout.
   localparam int          BASE_HI   = 20;
   localparam int          BASE_ALIGN = 5;
   localparam logic [31:0] BASE_MASK = 32'h001F_FFE0;

   // Stride register layout.
   localparam int          SEL0_LSB = 0;
   localparam int          SEL1_LSB = 3;
   localparam int          SEL2_LSB = 6;
   localparam int          SEL3_LSB = 9;
   localparam logic [31:0] STRIDE_MASK = 32'h0000_07FF;

   // Reset values; software must load both before use.
   localparam logic [31:0] BASE_RESET   = 32'h0000_0000;
   localparam logic [31:0] STRIDE_RESET = 32'h0000_0000;

   // Valid code windows and shift offsets of each selector.
   localparam logic [2:0] SEL0_LO = 3'h3;
   localparam logic [2:0] SEL0_HI = 3'h7;
   localparam logic [2:0] SEL1_LO = 3'h2;
   localparam logic [2:0] SEL1_HI = 3'h6;
   localparam logic [2:0] SEL2_LO = 3'h1;
   localparam logic [2:0] SEL2_HI = 3'h5;
   localparam logic [2:0] SEL3_LO = 3'h1;
   localparam logic [2:0] SEL3_HI = 3'h3;
   localparam logic [4:0] SHIFT_OFS_LOW = 5'h04;
   localparam logic [4:0] SHIFT_OFS_SEL3 = 5'h09;

   typedef struct packed {
      logic [15:0] y;
      logic [15:0] x;
   } pixel_coord_t;

   typedef struct packed {
      logic [1:0] row_multiplier_sel_3;
      logic [2:0] row_multiplier_sel_2;
      logic [2:0] row_multiplier_sel_1;
      logic [2:0] row_multiplier_sel_0;
   } stride_fields_t;

endpackage : blit_dst_pkg

// ===== rtl/blit_destination_address_gen.sv
/*
 * Destination pixel address generator of the drawing engine: base and
 * stride registers, operation snapshot and the address adder.
 * Assumes host writes arrive as single-cycle strobes with byte enables and
 * that the coordinate register logic pulses op_start when it is written.
 */
`timescale 1ns/1ps
module blit_destination_address_gen #(
   parameter int ADDR_W = 21
) (
   // Clock and reset.
   input  wire logic                      clk,
   input  wire logic                      rstn,
   // Host register port.
   input  wire logic                      host_wr,
   input  wire logic                      host_rd,
   input  wire logic [11:0]               host_addr,
   input  wire logic [3:0]                host_be,
   input  wire logic [31:0]               host_wdata,
   output logic      [31:0]               host_rdata,
   // Operation start from the coordinate register.
   input  wire logic                      op_start,
   // Pixel address requests and results.
   input  wire logic                      req_valid,
   input  wire blit_dst_pkg::pixel_coord_t req_coord,
   output logic                           addr_valid,
   output logic      [ADDR_W-1:0]         dram_addr
);

   logic [31:0]                  destination_base_address;
   logic [31:0]                  destination_line_stride;
   logic [31:0]                  next_base;
   logic [31:0]                  next_stride;
   logic [ADDR_W-1:0]            snap_base;
   blit_dst_pkg::stride_fields_t snap_stride;
   logic [ADDR_W-1:0]            next_addr;

   // Byte-lane merge; reserved and alignment bits are masked afterwards.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // One selector term: zero outside its code window, else Y shifted.
   function automatic logic [ADDR_W-1:0] term(input logic [2:0]  code,
                                              input logic [2:0]  lo,
                                              input logic [2:0]  hi,
                                              input logic [4:0]  ofs,
                                              input logic [15:0] y);
      logic [ADDR_W+15:0] wide;
      wide = '0;
      if (code >= lo && code <= hi) begin
         wide = {{ADDR_W{1'b0}}, y} << (code + ofs);
      end
      return wide[ADDR_W-1:0];
   endfunction : term

   always_comb begin
      next_base = merge(destination_base_address, host_wdata, host_be)
                  & blit_dst_pkg::BASE_MASK;
      next_stride = merge(destination_line_stride, host_wdata, host_be)
                    & blit_dst_pkg::STRIDE_MASK;
   end

   // Reset gives a known value although software must still program both.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         destination_base_address <= blit_dst_pkg::BASE_RESET;
      end else if (host_wr && host_addr == blit_dst_pkg::OFF_DEST_BASE) begin
         destination_base_address <= next_base;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         destination_line_stride <= blit_dst_pkg::STRIDE_RESET;
      end else if (host_wr
                   && host_addr == blit_dst_pkg::OFF_DEST_STRIDE) begin
         destination_line_stride <= next_stride;
      end
   end

   // Unmapped offsets read as zero.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_rdata <= 32'h0000_0000;
      end else if (host_rd) begin
         unique case (host_addr)
            blit_dst_pkg::OFF_DEST_BASE: begin
               host_rdata <= destination_base_address;
            end
            blit_dst_pkg::OFF_DEST_STRIDE: begin
               host_rdata <= destination_line_stride;
            end
            default: begin
               host_rdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // Snapshot lets software reload registers while an operation runs.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         snap_base   <= '0;
         snap_stride <= '0;
      end else if (op_start) begin
         snap_base   <= destination_base_address[ADDR_W-1:0];
         snap_stride <= destination_line_stride[10:0];
      end
   end

   // Stride is unsigned; line direction is applied by the Y stepper.
   always_comb begin
      next_addr = snap_base
         + ADDR_W'(req_coord.x)
         + term(snap_stride.row_multiplier_sel_0, blit_dst_pkg::SEL0_LO,
                blit_dst_pkg::SEL0_HI, blit_dst_pkg::SHIFT_OFS_LOW,
                req_coord.y)
         + term(snap_stride.row_multiplier_sel_1, blit_dst_pkg::SEL1_LO,
                blit_dst_pkg::SEL1_HI, blit_dst_pkg::SHIFT_OFS_LOW,
                req_coord.y)
         + term(snap_stride.row_multiplier_sel_2, blit_dst_pkg::SEL2_LO,
                blit_dst_pkg::SEL2_HI, blit_dst_pkg::SHIFT_OFS_LOW,
                req_coord.y)
         + term({1'b0, snap_stride.row_multiplier_sel_3},
                blit_dst_pkg::SEL3_LO, blit_dst_pkg::SEL3_HI,
                blit_dst_pkg::SHIFT_OFS_SEL3, req_coord.y);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_valid <= 1'b0;
         dram_addr  <= '0;
      end else begin
         addr_valid <= req_valid;
         if (req_valid) begin
            dram_addr <= next_addr;
         end
      end
   end

   a_base_reserved: assert property (
      @(posedge clk) disable iff (!rstn)
      (destination_base_address & ~blit_dst_pkg::BASE_MASK) == 32'h0000_0000)
      else $error("Base register reserved or alignment bits set.");

   a_base_aligned: assert property (
      @(posedge clk) disable iff (!rstn)
      addr_valid && $past(snap_stride) == '0 && $past(req_coord.x) == 16'h0000
      |-> dram_addr[4:0] == 5'h00)
      else $error("Address with zero X and stride is misaligned.");

   a_stride_reserved: assert property (
      @(posedge clk) disable iff (!rstn)
      destination_line_stride[31:11] == 21'h000000)
      else $error("Stride register reserved bits set.");

   a_half_write: assert property (
      @(posedge clk) disable iff (!rstn)
      host_wr && host_addr == blit_dst_pkg::OFF_DEST_STRIDE
      && host_be == 4'h3
      |=> destination_line_stride[10:0] == $past(host_wdata[10:0]))
      else $error("Halfword write to stride register not taken.");

   a_read_base: assert property (
      @(posedge clk) disable iff (!rstn)
      host_rd && host_addr == blit_dst_pkg::OFF_DEST_BASE && !host_wr
      ##1 !host_rd [*2] |-> ##1 host_rdata == $past(host_rdata))
      else $error("Read data changed without a read.");

   a_snap_take: assert property (
      @(posedge clk) disable iff (!rstn)
      op_start |=> snap_base == $past(destination_base_address[ADDR_W-1:0])
      && snap_stride == $past(destination_line_stride[10:0]))
      else $error("Snapshot not taken at operation start.");

   a_snap_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      !op_start |=> $stable(snap_base) && $stable(snap_stride))
      else $error("Snapshot changed without operation start.");

   a_addr_latency: assert property (
      @(posedge clk) disable iff (!rstn)
      req_valid |=> addr_valid)
      else $error("Address result not presented one cycle later.");

   a_addr_single: assert property (
      @(posedge clk) disable iff (!rstn)
      !req_valid |=> !addr_valid)
      else $error("Address result presented without a request.");

   a_low_codes: assert property (
      @(posedge clk) disable iff (!rstn)
      req_valid && snap_stride.row_multiplier_sel_0 < 3'h3
      && snap_stride[10:3] == 8'h00
      |=> dram_addr == $past(snap_base) + ADDR_W'($past(req_coord.x)))
      else $error("Low selector code did not give zero multiple.");

   a_sel3_top: assert property (
      @(posedge clk) disable iff (!rstn)
      req_valid && snap_stride == 11'h600
      |=> dram_addr == $past(snap_base) + ADDR_W'($past(req_coord.x))
          + ADDR_W'({$past(req_coord.y), 12'h000}))
      else $error("Fourth selector code 11 did not multiply by 4096.");

endmodule : blit_destination_address_gen

// ===== sim/blit_host_model.sv
/*
 * Host processor model: register writes and reads on the block's port.
 * Assumes the bench supplies the clock and calls these tasks in turn.
 */
`timescale 1ns/1ps
module blit_host_model (
   // Clock.
   input  wire logic        clk,
   // Host register port.
   output logic             host_wr,
   output logic             host_rd,
   output logic [11:0]      host_addr,
   output logic [3:0]       host_be,
   output logic [31:0]      host_wdata,
   input  wire logic [31:0] host_rdata
);
   initial begin
      {host_wr, host_rd, host_addr, host_be, host_wdata} = '0;
   end

   // Strobes are cleared and the address inverted after each access so nothing stale looks valid.
   task automatic wr(input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      @(negedge clk);
      {host_wr, host_addr, host_be, host_wdata} = {1'b1, a, be, d};
      @(negedge clk);
      {host_wr, host_addr, host_be, host_wdata} = {1'b0, ~a, ~be, ~d};
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(negedge clk);
      {host_rd, host_addr, host_be} = {1'b1, a, 4'hF};
      @(negedge clk);
      {host_rd, host_addr, host_be} = {1'b0, ~a, 4'h0};
      d = host_rdata;
   endtask : rd

   // Software loads both registers with a supported stride before drawing.
   task automatic load(input logic [31:0] b, input logic [31:0] s);
      wr(blit_dst_pkg::OFF_DEST_BASE, 4'hF, b);
      wr(blit_dst_pkg::OFF_DEST_STRIDE, 4'hF, s);
   endtask : load
endmodule : blit_host_model

// ===== sim/blit_destination_address_gen_bench.sv
/*
 * Self-checking bench for the destination address generator.
 * Assumes the host model file is compiled first.
 */
`timescale 1ns/1ps
module blit_destination_address_gen_bench;
   localparam int F0[8] = '{0, 0, 0, 128, 256, 512, 1024, 2048};
   localparam int F1[8] = '{0, 0, 64, 128, 256, 512, 1024, 0};
   localparam int F2[8] = '{0, 32, 64, 128, 256, 512, 0, 0};
   localparam int F3[4] = '{0, 1024, 2048, 4096};
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        host_wr, host_rd, op_start = 1'b0, req_valid = 1'b0;
   logic [11:0] host_addr;
   logic [3:0]  host_be;
   logic [31:0] host_wdata, host_rdata, rv, stride;
   logic        addr_valid;
   logic [20:0] dram_addr;
   blit_dst_pkg::pixel_coord_t req_coord = '0;
   int          error_cnt = 0;
   int          n_tests = 0;

   always #50 clk = ~clk;

   blit_host_model u_host (.clk(clk), .host_wr(host_wr), .host_rd(host_rd),
      .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
      .host_rdata(host_rdata));
   blit_destination_address_gen u_dut (.clk(clk), .rstn(rstn),
      .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
      .host_be(host_be), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .op_start(op_start), .req_valid(req_valid), .req_coord(req_coord),
      .addr_valid(addr_valid), .dram_addr(dram_addr));

   function automatic logic [20:0] expect_addr(logic [31:0] b, logic [31:0] s,
                                               logic [15:0] y, logic [15:0] x);
      int m;
      m = F0[s[2:0]] + F1[s[5:3]] + F2[s[8:6]] + F3[s[10:9]];
      return 21'((b & 32'h001F_FFE0) + x + y * m);
   endfunction : expect_addr

   task automatic report(logic [31:0] g, logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : report

   task automatic chk_rd(logic [11:0] a, logic [31:0] e);
      u_host.rd(a, rv);
      report(rv, e);
   endtask : chk_rd

   // A request is taken at one edge and answered at the next.
   task automatic chk_pix(logic [15:0] y, logic [15:0] x, logic [20:0] e);
      @(negedge clk);
      {req_valid, req_coord} = {1'b1, y, x};
      @(negedge clk);
      {req_valid, req_coord} = {1'b0, ~y, ~x};
      report({31'h0, addr_valid}, 32'h1);
      report({11'h0, dram_addr}, {11'h0, e});
      @(negedge clk);
      report({31'h0, addr_valid}, 32'h0);
   endtask : chk_pix

   task automatic start_op();
      @(negedge clk);
      op_start = 1'b1;
      @(negedge clk);
      op_start = 1'b0;
   endtask : start_op

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   initial begin
      #500000;
      error_cnt++;
      complete_run();
   end

   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      u_host.load(32'hFFFF_FFFF, 32'hFFFF_FFFF);
      chk_rd(blit_dst_pkg::OFF_DEST_BASE, 32'h001F_FFE0);
      chk_rd(blit_dst_pkg::OFF_DEST_STRIDE, 32'h0000_07FF);
      chk_rd(12'h01C, 32'h0000_0000);
      u_host.wr(blit_dst_pkg::OFF_DEST_STRIDE, 4'hF, 32'h0000_0005);
      u_host.wr(blit_dst_pkg::OFF_DEST_STRIDE, 4'hC, 32'hFFFF_FFFF);
      chk_rd(blit_dst_pkg::OFF_DEST_STRIDE, 32'h0000_0005);
      u_host.wr(blit_dst_pkg::OFF_DEST_STRIDE, 4'h3, 32'hFFFF_06A3);
      chk_rd(blit_dst_pkg::OFF_DEST_STRIDE, 32'h0000_06A3);
      // Every code of every selector, one field at a time.
      for (int f = 0; f < 4; f++) begin
         for (int c = 0; c < ((f == 3) ? 4 : 8); c++) begin
            stride = 32'(c) << (3 * f);
            u_host.load(32'h0012_347F, stride);
            start_op();
            chk_pix(16'h0005, 16'h0007, expect_addr(32'h0012_347F, stride,
                    16'h0005, 16'h0007));
         end
      end
      // All four terms at once, wrapping past the top of the range.
      u_host.load(32'h001F_FFE0, 32'h0000_06A3);
      start_op();
      u_host.wr(blit_dst_pkg::OFF_DEST_STRIDE, 4'hF, 32'h0000_0000);
      u_host.wr(blit_dst_pkg::OFF_DEST_BASE, 4'hF, 32'h0000_0000);
      chk_pix(16'hFFFF, 16'hFFFF, expect_addr(32'h001F_FFE0, 32'h06A3,
              16'hFFFF, 16'hFFFF));
      start_op();
      chk_pix(16'h0003, 16'h0010, 21'h00_0010);
      // Zero X and zero stride leave only the aligned base.
      u_host.load(32'h0012_347F, 32'h0000_0000);
      start_op();
      chk_pix(16'h0009, 16'h0000, 21'h12_3460);
      complete_run();
   end
endmodule : blit_destination_address_gen_bench
